// *** design/irm_pkg.sv ***
// Package for the ingress rate meter configuration block.
// Holds register numbers, field positions, reset values and command encodings.
package irm_pkg;

	// Register numbers, used directly as the register port address
	localparam logic [15:0] ADDR_ADMIT    = 16'h1849;
	localparam logic [15:0] ADDR_CFG      = 16'h184a;
	localparam logic [15:0] ADDR_CMD      = 16'h184b;
	localparam logic [15:0] ADDR_STATUS   = 16'h184c;
	localparam logic [15:0] ADDR_WR_DATA  = 16'h184d;
	localparam logic [15:0] ADDR_RD_DATA  = 16'h184e;

	// Field layout
	localparam int ADMIT_W      = 3;
	localparam int CFG_EN_BIT   = 0;
	localparam int CFG_MODE_LO  = 1;
	localparam int CFG_MODE_HI  = 2;
	localparam int CMD_IDX_LO   = 0;
	localparam int CMD_IDX_HI   = 4;
	localparam int CMD_TYPE_LO  = 5;
	localparam int CMD_TYPE_HI  = 6;
	localparam int CMD_DIR_BIT  = 7;
	localparam int CMD_W        = 8;
	localparam int STS_PEND_BIT = 0;
	localparam int ENTRY_W      = 16;
	localparam int IDX_W        = 5;
	localparam int PORT_W       = 2;
	localparam int PRIO_W       = 3;

	// Table geometry
	localparam int CIR_ENTRIES   = 24;
	localparam int PRIOS_PER_PORT = 8;

	// Reset values
	localparam logic [ENTRY_W-1:0] CIR_RESET   = 16'h0014;
	localparam logic [ENTRY_W-1:0] BURST_RESET = 16'h0600;
	localparam logic [ENTRY_W-1:0] DATA_RESET  = 16'h0000;
	localparam logic [CMD_W-1:0]   CMD_RESET   = 8'h00;
	localparam logic [31:0]        WORD_ZERO   = 32'h0000_0000;

	// Time per byte unit of a committed rate entry
	localparam int CIR_UNIT_NS = 20;

	// Rate modes
	typedef enum logic [1:0] {
		MODE_PORT_PRIO = 2'h0,
		MODE_PORT      = 2'h1,
		MODE_PRIO      = 2'h2,
		MODE_RSVD      = 2'h3
	} irm_mode_t;

	// Table targets
	typedef enum logic [1:0] {
		TYPE_RSVD = 2'h0,
		TYPE_CIR  = 2'h1,
		TYPE_CBS  = 2'h2,
		TYPE_EBS  = 2'h3
	} irm_type_t;

	// Command sequencer, Gray coded along idle -> busy -> finish
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_BUSY   = 2'h1,
		ST_FINISH = 2'h3
	} irm_state_t;

endpackage

// *** design/irm_top.sv ***
// Ingress rate meter configuration: admission of non-member ports, rate mode and
// enable, and the indirect command path to the committed rate and burst table.
// Assumes a simple single-cycle register port and lookup requests on clk.
// Functional notes
// - Admit bit accepts non-member ingress packets
// - Destination VLAN must still be active
// - Admit bits 2..0 serve ports 2..0
// - Mode: port+prio, port, prio, reserved
// - Enable bit turns metering on or off
// - Each command write launches table access
// - Command bit 7: one read, zero write
// - Type selects rate, committed or excess burst
// - Five-bit index picks one of 24 rates
// - Port+prio: eight entries per port, prio 0 lowest
// - Port only: entries 0..2 per port
// - Priority only: entry n serves priority n
// - Pending set during command, cleared after
// - Table entries sixteen bits, indirect only
// - Byte time is value plus one times 20ns
// - Burst entries reset to 0600h
`timescale 1ns/1ps

module irm_top
	import irm_pkg::*;
#(
	parameter int CMD_LAT = 2
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Register port
	input  wire logic [15:0]          reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [31:0]          reg_wdata,
	output logic      [31:0]          reg_rdata_r,
	// Admission check
	input  wire logic                 adm_req,
	input  wire logic [PORT_W-1:0]    adm_port,
	input  wire logic                 adm_member,
	input  wire logic                 adm_vlan_active,
	output logic                      adm_valid_r,
	output logic                      adm_accept_r,
	// Meter lookup
	input  wire logic                 mtr_req,
	input  wire logic [PORT_W-1:0]    mtr_port,
	input  wire logic [PRIO_W-1:0]    mtr_prio,
	output logic                      mtr_valid_r,
	output logic      [IDX_W-1:0]     mtr_index_r,
	output logic      [ENTRY_W-1:0]   mtr_rate_r,
	output logic      [ENTRY_W:0]     mtr_byte_time_r,
	// Meter configuration seen by the datapath
	output logic                      mtr_enable_r,
	output logic      [1:0]           mtr_mode_r,
	output logic      [ENTRY_W-1:0]   cbs_r,
	output logic      [ENTRY_W-1:0]   ebs_r,
	output logic                      op_pending_r
);

	localparam int CNT_W = $clog2(CMD_LAT + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CMD_LAT - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam int CHK_MAX = CMD_LAT + 1;

	if (CMD_LAT < 1) begin : g_lat_check
		$error("CMD_LAT must be at least one");
	end

	// Entry index that serves a given port and priority in a given mode
	function automatic logic [IDX_W-1:0] meter_index(input logic [1:0] mode,
			input logic [PORT_W-1:0] port, input logic [PRIO_W-1:0] prio);
		logic [IDX_W-1:0] idx;
		idx = '0;
		unique case (mode)
			MODE_PORT_PRIO: idx = IDX_W'({port, prio});
			MODE_PORT:      idx = IDX_W'(port);
			MODE_PRIO:      idx = IDX_W'(prio);
			MODE_RSVD:      idx = '0;
		endcase
		return idx;
	endfunction

	function automatic logic idx_ok(input logic [IDX_W-1:0] idx);
		return 32'(idx) < CIR_ENTRIES;
	endfunction

	// Register state
	logic [ADMIT_W-1:0]  admit_r,   admit_nxt;
	logic                en_r,      en_nxt;
	logic [1:0]          mode_r,    mode_nxt;
	logic [CMD_W-1:0]    cmd_r,     cmd_nxt;
	logic [ENTRY_W-1:0]  wdata_r,   wdata_nxt;
	logic [ENTRY_W-1:0]  rdata_r,   rdata_nxt;
	logic [31:0]         rd_nxt;
	logic                cmd_wr;

	assign cmd_wr = reg_wr && (reg_addr == ADDR_CMD);

	always_comb begin
		admit_nxt = admit_r;
		en_nxt    = en_r;
		mode_nxt  = mode_r;
		cmd_nxt   = cmd_r;
		wdata_nxt = wdata_r;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_ADMIT:   admit_nxt = reg_wdata[ADMIT_W-1:0];
				ADDR_CFG: begin
					en_nxt   = reg_wdata[CFG_EN_BIT];
					mode_nxt = reg_wdata[CFG_MODE_HI:CFG_MODE_LO];
				end
				ADDR_CMD:     cmd_nxt   = reg_wdata[CMD_W-1:0];
				ADDR_WR_DATA: wdata_nxt = reg_wdata[ENTRY_W-1:0];
				default:      ;
			endcase
		end
		rd_nxt = reg_rdata_r;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_ADMIT:   rd_nxt = 32'(admit_r);
				ADDR_CFG:     rd_nxt = 32'({mode_r, en_r});
				ADDR_CMD:     rd_nxt = 32'(cmd_r);
				ADDR_STATUS:  rd_nxt = 32'(op_pending_r);
				ADDR_WR_DATA: rd_nxt = 32'(wdata_r);
				ADDR_RD_DATA: rd_nxt = 32'(rdata_r);
				default:      rd_nxt = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			admit_r     <= '0;
			en_r        <= 1'b0;
			mode_r      <= MODE_PORT_PRIO;
			cmd_r       <= CMD_RESET;
			wdata_r     <= DATA_RESET;
			reg_rdata_r <= WORD_ZERO;
		end else begin
			admit_r     <= admit_nxt;
			en_r        <= en_nxt;
			mode_r      <= mode_nxt;
			cmd_r       <= cmd_nxt;
			wdata_r     <= wdata_nxt;
			reg_rdata_r <= rd_nxt;
		end
	end

	// Command sequencer and table; the register port reaches the table only from here, the meter lookup reads it directly
	irm_state_t          st_r,   st_nxt;
	logic [CNT_W-1:0]    cnt_r,  cnt_nxt;
	logic [ENTRY_W-1:0]  cir_r [CIR_ENTRIES];
	logic [ENTRY_W-1:0]  cir_nxt [CIR_ENTRIES];
	logic [ENTRY_W-1:0]  cbs_nxt, ebs_nxt;
	logic [IDX_W-1:0]    cmd_idx;
	logic [1:0]          cmd_type;
	logic                cmd_read;

	assign cmd_idx  = cmd_r[CMD_IDX_HI:CMD_IDX_LO];
	assign cmd_type = cmd_r[CMD_TYPE_HI:CMD_TYPE_LO];
	assign cmd_read = cmd_r[CMD_DIR_BIT];

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		cir_nxt   = cir_r;
		cbs_nxt   = cbs_r;
		ebs_nxt   = ebs_r;
		rdata_nxt = rdata_r;
		unique case (st_r)
			ST_IDLE: ;
			ST_BUSY: begin
				if (cnt_r == CNT_ZERO)
					st_nxt = ST_FINISH;
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			ST_FINISH: begin
				st_nxt = ST_IDLE;
				if (cmd_read) begin
					unique case (cmd_type)
						TYPE_CIR:  rdata_nxt = idx_ok(cmd_idx) ? cir_r[cmd_idx] : DATA_RESET;
						TYPE_CBS:  rdata_nxt = cbs_r;
						TYPE_EBS:  rdata_nxt = ebs_r;
						TYPE_RSVD: rdata_nxt = DATA_RESET;
					endcase
				end else begin
					unique case (cmd_type)
						TYPE_CIR: begin
							if (idx_ok(cmd_idx))
								cir_nxt[cmd_idx] = wdata_r;
						end
						TYPE_CBS:  cbs_nxt = wdata_r;
						TYPE_EBS:  ebs_nxt = wdata_r;
						TYPE_RSVD: ;
					endcase
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
		// every command write (re)starts the access
		if (cmd_wr) begin
			st_nxt  = ST_BUSY;
			cnt_nxt = CNT_LOAD;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r         <= ST_IDLE;
			cnt_r        <= '0;
			cbs_r        <= BURST_RESET;
			ebs_r        <= BURST_RESET;
			rdata_r      <= DATA_RESET;
			op_pending_r <= 1'b0;
			for (int i = 0; i < CIR_ENTRIES; i++)
				cir_r[i] <= CIR_RESET;
		end else begin
			st_r         <= st_nxt;
			cnt_r        <= cnt_nxt;
			cbs_r        <= cbs_nxt;
			ebs_r        <= ebs_nxt;
			rdata_r      <= rdata_nxt;
			op_pending_r <= (st_nxt != ST_IDLE);
			cir_r        <= cir_nxt;
		end
	end

	// Admission and meter lookup, one cycle after the request
	logic                adm_acc_nxt;
	logic [IDX_W-1:0]    lk_idx;
	logic [ENTRY_W-1:0]  lk_rate;

	always_comb begin
		// member or admit bit; VLAN must be active
		adm_acc_nxt = adm_req && adm_vlan_active && (adm_member || admit_r[adm_port]);
		lk_idx  = meter_index(mode_r, mtr_port, mtr_prio);
		lk_rate = idx_ok(lk_idx) ? cir_r[lk_idx] : DATA_RESET;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			adm_valid_r     <= 1'b0;
			adm_accept_r    <= 1'b0;
			mtr_valid_r     <= 1'b0;
			mtr_index_r     <= '0;
			mtr_rate_r      <= DATA_RESET;
			mtr_byte_time_r <= '0;
			mtr_enable_r    <= 1'b0;
			mtr_mode_r      <= MODE_PORT_PRIO;
		end else begin
			adm_valid_r     <= adm_req;
			adm_accept_r    <= adm_acc_nxt;
			mtr_valid_r     <= mtr_req;
			mtr_index_r     <= lk_idx;
			mtr_rate_r      <= lk_rate;
			mtr_byte_time_r <= {1'b0, lk_rate} + 17'h00001;
			mtr_enable_r    <= en_r;
			mtr_mode_r      <= mode_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_admit_nonmember: assert property (adm_req |=> adm_accept_r == ($past(adm_vlan_active)
			&& ($past(adm_member) || $past(admit_r[adm_port]))))
		else $error("admission result wrong");
	chk_inactive_vlan: assert property (adm_req && !adm_vlan_active |=> !adm_accept_r)
		else $error("inactive VLAN admitted");
	chk_admit_field: assert property (reg_wr && reg_addr == ADDR_ADMIT |=>
			admit_r == $past(reg_wdata[ADMIT_W-1:0]))
		else $error("admit field not stored");
	chk_mode_enable: assert property (reg_wr && reg_addr == ADDR_CFG |=> ##1
			mtr_enable_r == $past(reg_wdata[CFG_EN_BIT], 2)
			&& mtr_mode_r == $past(reg_wdata[CFG_MODE_HI:CFG_MODE_LO], 2))
		else $error("enable or mode not applied");
	chk_pend_window: assert property (cmd_wr |=> op_pending_r ##[CHK_MAX:CHK_MAX]
			(!op_pending_r || $past(cmd_wr, 1) || $past(cmd_wr, 2) || $past(cmd_wr, 3)))
		else $error("pending flag timing wrong");
	chk_launch_write: assert property (cmd_wr && !reg_wdata[CMD_DIR_BIT]
			&& reg_wdata[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_CBS ##1 (!cmd_wr && !reg_wr)[*3]
			|=> cbs_r == $past(wdata_r))
		else $error("committed burst write lost");
	chk_read_back: assert property (st_r == ST_FINISH && cmd_read && cmd_type == TYPE_EBS
			|=> rdata_r == $past(ebs_r))
		else $error("excess burst read wrong");
	chk_cir_write: assert property (st_r == ST_FINISH && !cmd_read && cmd_type == TYPE_CIR
			&& idx_ok(cmd_idx) |=> cir_r[$past(cmd_idx)] == $past(wdata_r))
		else $error("rate entry write wrong");
	chk_port_prio_idx: assert property (mtr_req && mode_r == MODE_PORT_PRIO |=>
			mtr_index_r == 5'(32'($past(mtr_port)) * PRIOS_PER_PORT + 32'($past(mtr_prio))))
		else $error("port and priority index wrong");
	chk_port_idx: assert property (mtr_req && mode_r == MODE_PORT |=>
			mtr_index_r == 5'($past(mtr_port)))
		else $error("port index wrong");
	chk_prio_idx: assert property (mtr_req && mode_r == MODE_PRIO |=>
			mtr_index_r == 5'($past(mtr_prio)))
		else $error("priority index wrong");
	chk_byte_time: assert property (mtr_valid_r |->
			mtr_byte_time_r == {1'b0, mtr_rate_r} + 17'h00001)
		else $error("byte time not value plus one");

	property burst_reset_p;
		@(posedge clk) $fell(rst) |-> cbs_r == BURST_RESET && ebs_r == BURST_RESET;
	endproperty
	chk_burst_reset: assert property (burst_reset_p)
		else $error("burst reset value wrong");

endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the ingress rate meter configuration block.
// Drives register, admission and lookup ports at the falling edge.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end

module tb_top;
	import irm_pkg::*;

	localparam int LAT = 2;
	logic              clk, rst, reg_wr, reg_rd, adm_req, adm_member, adm_vlan_active, mtr_req;
	logic [15:0]       reg_addr;
	logic [31:0]       reg_wdata, reg_rdata_r, q;
	logic [PORT_W-1:0] adm_port, mtr_port;
	logic [PRIO_W-1:0] mtr_prio;
	logic              adm_valid_r, adm_accept_r, mtr_valid_r, mtr_enable_r, op_pending_r;
	logic [IDX_W-1:0]  mtr_index_r;
	logic [15:0]       mtr_rate_r, cbs_r, ebs_r;
	logic [16:0]       mtr_byte_time_r;
	logic [1:0]        mtr_mode_r;
	int                errors, cmp_count, cyc, cir[24], cbs, ebs, admit, ix, e;
	bit   [31:0]       rng = 32'h28;

	irm_top #(.CMD_LAT(LAT)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .adm_req(adm_req),
		.adm_port(adm_port), .adm_member(adm_member), .adm_vlan_active(adm_vlan_active),
		.adm_valid_r(adm_valid_r), .adm_accept_r(adm_accept_r), .mtr_req(mtr_req),
		.mtr_port(mtr_port), .mtr_prio(mtr_prio), .mtr_valid_r(mtr_valid_r),
		.mtr_index_r(mtr_index_r), .mtr_rate_r(mtr_rate_r), .mtr_byte_time_r(mtr_byte_time_r),
		.mtr_enable_r(mtr_enable_r), .mtr_mode_r(mtr_mode_r), .cbs_r(cbs_r), .ebs_r(ebs_r),
		.op_pending_r(op_pending_r));

	function automatic int nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return int'(rng & 32'h7fff_ffff);
	endfunction

	task automatic close_out();
		$display("counts: %0d compares, %0d errors", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		q = reg_rdata_r;
	endtask

	// Launch a command and count the cycles that pending stays up
	task automatic cmd(input logic [7:0] c);
		int n;
		n = 0;
		wr(ADDR_CMD, {nxt() & 32'hffff_ff00} | {24'h0, c});
		`CHK("pend_set", 1'b1, op_pending_r)
		while (op_pending_r === 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		`CHK("pend_cycles", LAT + 1, n)
		rd(ADDR_STATUS);
		`CHK("pend_clear", 32'h0, q)
	endtask

	task automatic tbl(input logic rw, input logic [1:0] ty, input logic [4:0] i, input logic [15:0] d);
		if (!rw) begin
			wr(ADDR_WR_DATA, {16'h0, d});
			cmd({1'b0, ty, i});
			if (ty == TYPE_CIR && i < 24) cir[i] = d;
			if (ty == TYPE_CBS) cbs = d;
			if (ty == TYPE_EBS) ebs = d;
		end else begin
			cmd({1'b1, ty, i});
			rd(ADDR_RD_DATA);
			e = (ty == TYPE_CBS) ? cbs : (ty == TYPE_EBS) ? ebs : (ty == TYPE_CIR && i < 24) ? cir[i] : 0;
			`CHK("rd_data", e, q)
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		{rst, reg_wr, reg_rd, adm_req, adm_member, adm_vlan_active, mtr_req} = 7'h40;
		{reg_addr, reg_wdata, adm_port, mtr_port, mtr_prio} = '0;
		for (int i = 0; i < 24; i++) cir[i] = 16'h0014;
		cbs = 16'h0600;
		ebs = 16'h0600;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		`CHK("cbs_rst", 16'h0600, cbs_r)
		`CHK("ebs_rst", 16'h0600, ebs_r)
		`CHK("en_rst", 1'b0, mtr_enable_r)
		for (int a = 16'h1849; a <= 16'h1850; a++) begin
			rd(a[15:0]);
			`CHK("reg_rst", 32'h0, q)
		end
		admit = nxt() & 7;
		wr(ADDR_ADMIT, nxt() & 32'hffff_fff8 | admit);
		rd(ADDR_ADMIT);
		`CHK("admit_rb", admit[2:0], q[2:0])
		// status bit while busy; reserved type only pulses pending
		wr(ADDR_CMD, 32'h0000_0000);
		rd(ADDR_STATUS);
		`CHK("sts_busy", 32'h1, q)
		repeat (3) @(negedge clk);
		`CHK("sts_idle", 1'b0, op_pending_r)
		$display("test registers done");
		tbl(1'b1, TYPE_CIR, 5'h5, 16'h0);
		tbl(1'b1, TYPE_CBS, 5'h0, 16'h0);
		for (int k = 0; k < 40; k++) begin
			// index kept in range, every eighth deliberately beyond
			ix = (k % 8 == 7) ? 24 + nxt() % 8 : nxt() % 24;
			e = 1 + nxt() % 3;
			tbl(1'b0, e[1:0], ix[4:0], 16'(nxt()));
			tbl(1'b1, e[1:0], ix[4:0], 16'h0);
		end
		tbl(1'b0, TYPE_RSVD, 5'h3, 16'hbeef);
		tbl(1'b1, TYPE_CIR, 5'h3, 16'h0);
		tbl(1'b1, TYPE_RSVD, 5'h3, 16'h0);
		`CHK("cbs_out", cbs[15:0], cbs_r)
		`CHK("ebs_out", ebs[15:0], ebs_r)
		$display("test table done");
		for (int k = 0; k < 40; k++) begin
			@(negedge clk);
			adm_req = 1'b1;
			adm_port = 2'(nxt() % 3);
			{adm_member, adm_vlan_active} = 2'(nxt());
			@(negedge clk);
			adm_req = 1'b0;
			`CHK("adm_valid", 1'b1, adm_valid_r)
			`CHK("adm_acc", adm_vlan_active & (adm_member | admit[adm_port]), adm_accept_r)
		end
		$display("test admission done");
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CFG, {29'h0, m[1:0], m[0] ^ 1'b1});
			repeat (3) @(negedge clk);
			`CHK("mode", m[1:0], mtr_mode_r)
			`CHK("enable", m[0] ^ 1'b1, mtr_enable_r)
			for (int k = 0; k < 16; k++) begin
				@(negedge clk);
				mtr_req = 1'b1;
				mtr_port = 2'(nxt() % 3);
				mtr_prio = 3'(nxt());
				ix = (m == 0) ? mtr_port * 8 + mtr_prio : (m == 1) ? mtr_port : (m == 2) ? mtr_prio : 0;
				@(negedge clk);
				mtr_req = 1'b0;
				`CHK("mtr_valid", 1'b1, mtr_valid_r)
				`CHK("mtr_index", ix[4:0], mtr_index_r)
				`CHK("mtr_rate", cir[ix][15:0], mtr_rate_r)
				`CHK("byte_time", cir[ix][16:0] + 17'h1, mtr_byte_time_r)
			end
		end
		$display("test metering done");
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		`CHK("cbs_rst2", 16'h0600, cbs_r)
		`CHK("ebs_rst2", 16'h0600, ebs_r)
		rd(ADDR_ADMIT);
		`CHK("admit_rst2", 32'h0, q)
		$display("test reset done");
		close_out();
	end
endmodule
